// ### rtl/rcg_refclk_gate.sv
// Reference clock fan-out enable and clock request merge logic
// Behaviour
// - Fan-out buffer enabled while the power-down strap samples low.
// - Enabled buffer copies the one 100MHz input onto every output pair.
// - Strap high disables buffer; core takes the dedicated core reference input.
// - Configuration field bits turn individual output pairs off.
// - Each output gated by its own request line and port clock status.
// - Three downstream requests merge onto the upstream request line.
// - Undriven (high) downstream request stops that port's output.
// - All downstream requests high releases the upstream line to pull-up.
// - Upstream line high stops the output feeding the upstream port.
module rcg_refclk_gate (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strap and configuration
  input wire logic refbufPowerdownStrap,
  input wire logic [rcg_pkg::CfgW-1:0] clkBufCtrl,
  input wire logic [rcg_pkg::NumOut-1:0] portClkOn,
  // Clock request pins, open-drain
  input wire logic [rcg_pkg::NumOut-1:0] clockRequestNIn,
  output logic [rcg_pkg::NumOut-1:0] clockRequestNOut,
  output logic [rcg_pkg::NumOut-1:0] clockRequestNOe,
  // Fan-out enables and core reference select
  output logic [rcg_pkg::NumOut-1:0] fanoutEnable,
  output logic bufferEnable,
  output logic coreRefSelCore
);

  // Lines above the upstream one belong to the downstream ports
  localparam int DownLo = rcg_pkg::NumOut - rcg_pkg::NumDown;
  localparam int SyncMid = rcg_pkg::SyncDepth - 2;
  localparam int SyncLast = rcg_pkg::SyncDepth - 1;

  // Pin synchronisers; stage 0 feeds stage 1 and nothing else
  logic [rcg_pkg::SyncDepth-1:0] strapSync_r;
  logic [rcg_pkg::SyncDepth-1:0] strapSync_nxt;
  logic strap_r;
  logic strap_nxt;
  logic [rcg_pkg::SyncDepth-1:0][rcg_pkg::NumOut-1:0] reqSync_r;
  logic [rcg_pkg::SyncDepth-1:0][rcg_pkg::NumOut-1:0] reqSync_nxt;
  logic [rcg_pkg::NumOut-1:0] reqStable_r;
  logic [rcg_pkg::NumOut-1:0] reqStable_nxt;

  // Same-domain inputs, registered once
  logic [rcg_pkg::CfgW-1:0] cfg_r;
  logic [rcg_pkg::NumOut-1:0] portOn_r;

  // Output registers
  logic [rcg_pkg::NumOut-1:0] fanout_r;
  logic [rcg_pkg::NumOut-1:0] fanout_nxt;
  logic bufEn_r;
  logic bufEn_nxt;
  logic coreSel_r;
  logic coreSel_nxt;
  logic [rcg_pkg::NumOut-1:0] reqOe_r;
  logic [rcg_pkg::NumOut-1:0] reqOe_nxt;
  logic [rcg_pkg::NumOut-1:0] odLow_r;
  logic [rcg_pkg::NumOut-1:0] odLow_nxt;

  // Decoded request view
  rcg_pkg::rcg_gate_s gate;
  logic anyDownReq;
  logic [rcg_pkg::NumOut-1:0] strapAllow;
  logic [rcg_pkg::NumOut-1:0] cfgOff;
  logic [rcg_pkg::NumOut-1:0] reqActive;

  // A level counts only once two stages agree, so a one-cycle glitch never reaches the outputs
  function automatic logic settle(input logic mid, input logic last, input logic held);
    logic same;
    same = ~(mid ^ last);
    return (same & last) | (~same & held);
  endfunction

  // One output runs only if strap, config, request and port status all allow it
  function automatic logic gateOne(input logic allow, input logic off, input logic active,
    input logic on);
    return allow & ~off & active & on;
  endfunction

  // Shift the pins in; the newest sample sits at stage 0
  assign strapSync_nxt = {strapSync_r[SyncMid:0], refbufPowerdownStrap};
  assign reqSync_nxt = {reqSync_r[SyncMid:0], clockRequestNIn};
  // The strap is a level; a change mid-run simply re-gates every output
  assign strap_nxt = settle(strapSync_r[SyncMid], strapSync_r[SyncLast], strap_r);

  always_comb begin
    reqStable_nxt = reqStable_r;
    for (int i = 0; i < rcg_pkg::NumOut; i++) begin
      reqStable_nxt[i] = settle(reqSync_r[SyncMid][i], reqSync_r[SyncLast][i], reqStable_r[i]);
    end
  end

  // Filtered request levels and registered port status travel together
  assign gate.reqIn = reqStable_r;
  assign gate.portClkOn = portOn_r;

  // Any low downstream request pulls the upstream line low
  assign anyDownReq = ~&gate.reqIn[rcg_pkg::NumOut-1:DownLo];
  assign strapAllow = {rcg_pkg::NumOut{~strap_r}};
  // Bits above the output count are spare and ignored
  assign cfgOff = cfg_r[rcg_pkg::NumOut-1:0];
  // Line 0 also carries the root complex, so its level reflects either party
  assign reqActive = ~gate.reqIn;

  always_comb begin
    fanout_nxt = '0;
    for (int i = 0; i < rcg_pkg::NumOut; i++) begin
      fanout_nxt[i] = gateOne(strapAllow[i], cfgOff[i], reqActive[i], gate.portClkOn[i]);
    end
  end

  assign bufEn_nxt = ~strap_r;
  assign coreSel_nxt = strap_r;

  // Only the upstream line is ever driven; downstream lines belong to the endpoints
  always_comb begin
    reqOe_nxt = '0;
    reqOe_nxt[rcg_pkg::UpIdx] = anyDownReq;
  end

  // Open-drain data: the pin is only ever pulled low, never driven high
  assign odLow_nxt = '0;

  // Reset leaves every request released and every clock output stopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapSync_r <= '0;
    end else begin
      strapSync_r <= strapSync_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_r <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reqSync_r <= '1;
    end else begin
      reqSync_r <= reqSync_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reqStable_r <= '1;
    end else begin
      reqStable_r <= reqStable_nxt;
    end
  end

  // Config and port status come from the same clock domain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= rcg_pkg::CfgReset;
    end else begin
      cfg_r <= clkBufCtrl;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      portOn_r <= '0;
    end else begin
      portOn_r <= portClkOn;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fanout_r <= '0;
    end else begin
      fanout_r <= fanout_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bufEn_r <= 1'b0;
    end else begin
      bufEn_r <= bufEn_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreSel_r <= 1'b0;
    end else begin
      coreSel_r <= coreSel_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reqOe_r <= '0;
    end else begin
      reqOe_r <= reqOe_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      odLow_r <= '0;
    end else begin
      odLow_r <= odLow_nxt;
    end
  end

  // Outputs straight from their registers
  assign fanoutEnable = fanout_r;
  assign bufferEnable = bufEn_r;
  assign coreRefSelCore = coreSel_r;
  assign clockRequestNOe = reqOe_r;
  assign clockRequestNOut = odLow_r;

endmodule // rcg_refclk_gate

// ### rtl/rcg_pkg.sv
// Package for reference clock buffer and clock request gating
package rcg_pkg;
  localparam int NumOut = 4;
  localparam int NumDown = 3;
  localparam int UpIdx = 0;
  localparam int CfgW = 8;
  localparam logic [CfgW-1:0] CfgReset = 8'h00;
  localparam int SyncDepth = 3;

  // Request lines and port clock status as seen by the block, one bit per output
  typedef struct packed {
    logic [NumOut-1:0] reqIn;
    logic [NumOut-1:0] portClkOn;
  } rcg_gate_s;
endpackage

// ### verification/rcg_refclk_gate_sva.sv
// Port checker for buffer enable, fan-out gating and request merge
module rcg_refclk_gate_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Design inputs
  input wire logic refbufPowerdownStrap,
  input wire logic [7:0] clkBufCtrl,
  input wire logic [3:0] portClkOn,
  input wire logic [3:0] clockRequestNIn,
  // Design outputs
  input wire logic [3:0] clockRequestNOut,
  input wire logic [3:0] clockRequestNOe,
  input wire logic [3:0] fanoutEnable,
  input wire logic bufferEnable,
  input wire logic coreRefSelCore
);
  logic [2:0] upCnt;
  wire ok = upCnt == 3'h7;
  // Past values reach five edges back, so hold the checks until the counter has run seven edges past reset
  always_ff @(posedge core_clk or posedge rst) upCnt <= rst ? 3'h0 : upCnt + 3'(!ok);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_bufOn; ok |-> bufferEnable == !$past(refbufPowerdownStrap, 5); endproperty
  a_bufOn: assert property (p_bufOn) else $error("buffer enable");
  property p_coreSel; ok |-> coreRefSelCore == $past(refbufPowerdownStrap, 5); endproperty
  a_coreSel: assert property (p_coreSel) else $error("core select");
  property p_fan; ok |-> fanoutEnable == (~{4{$past(refbufPowerdownStrap, 5)}}
    & ~$past(clkBufCtrl[3:0], 2) & ~$past(clockRequestNIn, 5) & $past(portClkOn, 2)); endproperty
  a_fan: assert property (p_fan) else $error("fan-out gating");
  property p_merge; ok |-> clockRequestNOe[0] == !(&$past(clockRequestNIn[3:1], 5)); endproperty
  a_merge: assert property (p_merge) else $error("merge");
  property p_odData; clockRequestNOut == 4'h0 && clockRequestNOe[3:1] == 3'h0; endproperty
  a_odData: assert property (p_odData) else $error("open drain");
  property p_cfgOff; ok |-> !(fanoutEnable & $past(clkBufCtrl[3:0], 2)); endproperty
  a_cfgOff: assert property (p_cfgOff) else $error("cfg off");
  property p_upStop; ok && $past(clockRequestNIn[0], 5) |-> !fanoutEnable[0]; endproperty
  a_upStop: assert property (p_upStop) else $error("upstream stop");
  property p_downStop; ok |-> !(fanoutEnable[3:1] & $past(clockRequestNIn[3:1], 5)); endproperty
  a_downStop: assert property (p_downStop) else $error("downstream stop");
  property p_release; $rose(&clockRequestNIn[3:1]) |-> ##5 !clockRequestNOe[0]; endproperty
  a_release: assert property (p_release) else $error("release");
endmodule // rcg_refclk_gate_sva
bind rcg_refclk_gate rcg_refclk_gate_sva u_rcg_refclk_gate_sva (
  .core_clk(core_clk),
  .rst(rst),
  .refbufPowerdownStrap(refbufPowerdownStrap),
  .clkBufCtrl(clkBufCtrl),
  .portClkOn(portClkOn),
  .clockRequestNIn(clockRequestNIn),
  .clockRequestNOut(clockRequestNOut),
  .clockRequestNOe(clockRequestNOe),
  .fanoutEnable(fanoutEnable),
  .bufferEnable(bufferEnable),
  .coreRefSelCore(coreRefSelCore)
);

// ### verification/rcg_far_end.sv
// Root complex on line 0 and endpoints on lines 3:1, with pull-ups
module rcg_far_end (
  input wire logic [3:0] pend,
  input wire logic [3:0] oe,
  output wire logic [3:0] lineN
);
  // An idle party releases its line, so only a driver pulls it low
  assign lineN = ~(pend | oe);
endmodule // rcg_far_end

// ### verification/test_refclk_buffer_request_gating.sv
// Bench for clock buffer enable and request gating
module test_refclk_buffer_request_gating;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, strap = 0, bufEn, selCore;
  logic [7:0] cfg = 8'h00;
  logic [3:0] on = 4'hf, pend = 4'h0, lineN, nOut, oe, fan;
  int err_count = 0, checks = 0, cyc = 0;
  rcg_refclk_gate u_rcg_refclk_gate (.core_clk(core_clk), .rst(rst),
    .refbufPowerdownStrap(strap), .clkBufCtrl(cfg), .portClkOn(on), .clockRequestNIn(lineN),
    .clockRequestNOut(nOut), .clockRequestNOe(oe), .fanoutEnable(fan),
    .bufferEnable(bufEn), .coreRefSelCore(selCore));
  rcg_far_end u_rcg_far_end (.pend(pend), .oe(oe), .lineN(lineN));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 2000) begin
    err_count++;
    results();
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Line 0 is low when the root complex or the merged request pulls it
  function automatic logic [3:0] expFan(logic s, logic [7:0] c, logic [3:0] o, logic [3:0] p);
    logic [3:0] rq;
    rq = {p[3:1], p[0] | (|p[3:1])};
    return ~{4{s}} & ~c[3:0] & rq & o;
  endfunction
  function automatic logic [3:0] expOe(logic [3:0] p);
    return {3'h0, |p[3:1]};
  endfunction
  // Upstream line also sees the merged request, so allow two sync passes
  task automatic step(logic s, logic [7:0] c, logic [3:0] o, logic [3:0] p);
    strap = s;
    cfg = c;
    on = o;
    pend = p;
    repeat (12) @(negedge core_clk);
    chk(fan, expFan(s, c, o, p));
    chk(oe, expOe(p));
    chk({2'h0, bufEn, selCore}, {2'h0, !s, s});
    chk(nOut, 4'h0);
    $display("test done at %0t", $time);
  endtask
  initial begin
    void'($urandom(32'he5e6704d));
    repeat (3) @(negedge core_clk);
    rst = 0;
    for (int i = 0; i < 16; i++) step(0, 8'h00, 4'hf, 4'(i));
    for (int i = 0; i < 4; i++) step(0, 8'h01 << i, 4'hf, 4'hf);
    step(0, 8'h00, 4'h5, 4'hf);
    step(1, 8'h00, 4'hf, 4'hf);
    // Mid-run reset with requests pending: all clocks off, line released
    rst = 1;
    repeat (3) @(negedge core_clk);
    chk(fan | oe, 4'h0);
    chk({2'h0, bufEn, selCore}, 4'h0);
    rst = 0;
    for (int i = 0; i < 30; i++) step(1'($urandom), 8'($urandom), 4'($urandom), 4'($urandom));
    results();
  end
endmodule // test_refclk_buffer_request_gating
